/* dv/cdsd_decoder_props.sv */
// Port checker for the sector stream decoder, bound to its top module
module cdsd_props (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic [2:0] FORMAT,
	input wire logic DAC_SELECT,
	input wire logic CORR_DONE,
	input wire logic HOST_READY,
	input wire logic DAC_READY,
	input wire logic BUF_WR,
	input wire logic CORR_REQ,
	input wire logic HOST_VALID,
	input wire logic [cdsd_pkg::BYTE_W-1:0] HOST_DATA,
	input wire logic DAC_VALID,
	input wire logic [cdsd_pkg::SECT_CNT_W-1:0] WRITTEN_COUNT,
	input wire logic [cdsd_pkg::SECT_CNT_W-1:0] CORRECTED_COUNT,
	input wire logic [cdsd_pkg::SECT_CNT_W-1:0] SENT_COUNT,
	input wire logic [1:0] STATE
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	// Open correction request, closed by the engine's done pulse
	logic pend;
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			pend <= 1'b0;
		end else if (CORR_REQ) begin
			pend <= 1'b1;
		end else if (CORR_DONE) begin
			pend <= 1'b0;
		end
	end
	chk_host_hold: assert property (HOST_VALID && !HOST_READY |=> HOST_VALID && $stable(HOST_DATA))
		else $error("host byte dropped or changed while stalled");
	chk_dac_hold: assert property (DAC_VALID && !DAC_READY |=> DAC_VALID)
		else $error("dac byte dropped while stalled");
	chk_corr_pulse: assert property (CORR_REQ |=> !CORR_REQ)
		else $error("correction request longer than one cycle");
	chk_corr_order: assert property (CORR_REQ |-> !pend)
		else $error("correction request while one is open");
	chk_dvd_block: assert property (CORR_REQ && FORMAT == 3'h5
		|=> WRITTEN_COUNT - CORRECTED_COUNT >= cdsd_pkg::ECC_BLK_CNT)
		else $error("dvd correction before a full block");
	chk_dvd_release: assert property (HOST_VALID && FORMAT == 3'h5
		|-> CORRECTED_COUNT >= cdsd_pkg::ECC_BLK_CNT)
		else $error("dvd host data before block corrected");
	chk_audio_no_c3: assert property (FORMAT == 3'h0 |-> !CORR_REQ)
		else $error("buffer correction requested for audio");
	chk_dac_route: assert property (DAC_VALID |-> FORMAT == 3'h0 && DAC_SELECT)
		else $error("dac output outside audio routing");
	chk_buf_room: assert property (WRITTEN_COUNT - SENT_COUNT <= cdsd_pkg::BUF_CAP)
		else $error("buffer overrun of unsent sectors");
	chk_sent_order: assert property (FORMAT != 3'h0 |-> SENT_COUNT <= CORRECTED_COUNT)
		else $error("sector sent before corrected");
	chk_idle_quiet: assert property ((STATE == 2'h0) [*3] |-> !BUF_WR)
		else $error("buffer write while idle");
	cover property (CORR_REQ);
	cover property (HOST_VALID && !HOST_READY);
	cover property (DAC_VALID && DAC_READY);
endmodule

bind cdsd_decoder cdsd_props i_props (.CLOCK, .RST, .FORMAT, .DAC_SELECT, .CORR_DONE,
	.HOST_READY, .DAC_READY, .BUF_WR, .CORR_REQ, .HOST_VALID, .HOST_DATA, .DAC_VALID,
	.WRITTEN_COUNT, .CORRECTED_COUNT, .SENT_COUNT, .STATE);

/* dv/cdsd_far_model.sv */
// Correction engine, host side and audio DAC side seen from the decoder
module cdsd_far_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic corr_req,
	output logic corr_done,
	output logic host_ready,
	output logic dac_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] wait_cnt;
	logic [3:0] phase;
	logic slow;
	// Sinks stall on fixed slots so the output FIFO backs up now and then
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			phase <= 4'h0;
			host_ready <= 1'b0;
			dac_ready <= 1'b0;
		end else begin
			phase <= phase + 4'h1;
			host_ready <= phase != 4'hf;
			dac_ready <= phase != 4'h7;
		end
	end
	// Alternates a prompt and a slow answer to each correction request
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			wait_cnt <= 6'h00;
			slow <= 1'b0;
			corr_done <= 1'b0;
		end else begin
			corr_done <= wait_cnt == 6'h01;
			if (corr_req) begin
				wait_cnt <= slow ? 6'h28 : 6'h02;
				slow <= !slow;
			end else if (wait_cnt != 6'h00) begin
				wait_cnt <= wait_cnt - 6'h01;
			end
		end
	end
endmodule

/* dv/testbench.sv */
// Self-checking bench for the sector stream decoder
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLOCK = 1'b0;
	logic RST = 1'b1;
	logic START = 1'b0;
	logic [2:0] FORMAT = 3'h0;
	logic SYM_VALID = 1'b0;
	logic [15:0] SYM_DATA = 16'h0000;
	logic SYM_FLAG = 1'b0;
	logic SUB_VALID = 1'b0;
	logic DAC_SELECT = 1'b0;
	logic CE = 1'b1;
	logic CORR_DONE, HOST_READY, DAC_READY, BUF_WR, BUF_WFLAG, CORR_REQ, HOST_VALID, DAC_VALID;
	logic [7:0] BUF_WDATA, HOST_DATA, DAC_DATA;
	logic [1:0] STATE;
	logic [11:0] WRITTEN_COUNT, CORRECTED_COUNT, SENT_COUNT;
	logic [31:0] host_bytes, dac_bytes, corr_reqs, wflags;
	logic [31:0] cycles = 32'h0;
	// Bit 8 marks that the first byte has been captured
	logic [8:0] first_w, first_o;
	int errors = 0;
	int n_compared = 0;
	always #4 CLOCK = ~CLOCK;
	cdsd_decoder i_dut (.CLOCK(CLOCK), .RST(RST), .CE(CE), .START(START), .FORMAT(FORMAT),
		.TARGET_ID(24'h000000), .SYM_VALID(SYM_VALID), .SYM_DATA(SYM_DATA),
		.SYM_FLAG(SYM_FLAG), .SUB_VALID(SUB_VALID), .SUB_DATA(8'h00), .CORR_DONE(CORR_DONE),
		.DAC_SELECT(DAC_SELECT), .HOST_READY(HOST_READY), .DAC_READY(DAC_READY),
		.BUF_WR(BUF_WR), .BUF_WDATA(BUF_WDATA), .BUF_WFLAG(BUF_WFLAG), .CORR_REQ(CORR_REQ),
		.HOST_VALID(HOST_VALID), .HOST_DATA(HOST_DATA), .DAC_VALID(DAC_VALID),
		.DAC_DATA(DAC_DATA), .DAC_FLAG(), .WRITTEN_COUNT(WRITTEN_COUNT),
		.CORRECTED_COUNT(CORRECTED_COUNT), .SENT_COUNT(SENT_COUNT), .STATE(STATE));
	cdsd_far_model i_far (.clk(CLOCK), .rst(RST), .corr_req(CORR_REQ), .corr_done(CORR_DONE),
		.host_ready(HOST_READY), .dac_ready(DAC_READY));
	// Traffic and first bytes seen at the ports, cleared by each reset
	always @(posedge CLOCK) begin
		cycles <= cycles + 32'h1;
		if (RST) begin
			host_bytes <= 32'h0;
			dac_bytes <= 32'h0;
			corr_reqs <= 32'h0;
			wflags <= 32'h0;
			first_w <= 9'h000;
			first_o <= 9'h000;
		end else begin
			host_bytes <= host_bytes + (HOST_VALID && HOST_READY);
			dac_bytes <= dac_bytes + (DAC_VALID && DAC_READY);
			corr_reqs <= corr_reqs + CORR_REQ;
			wflags <= wflags + (BUF_WR && BUF_WFLAG);
			if (BUF_WR && !first_w[8]) begin
				first_w <= {1'b1, BUF_WDATA};
			end
			if (HOST_VALID && HOST_READY && !first_o[8]) begin
				first_o <= {1'b1, HOST_DATA};
			end else if (DAC_VALID && DAC_READY && !first_o[8]) begin
				first_o <= {1'b1, DAC_DATA};
			end
		end
		// Clean run is close to 98,000 cycles; small margin above it
		if (cycles == 32'd105000) begin
			errors++;
			wrap_up();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		if (errors == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Second reset between runs also clears the sector counts
	task automatic restart(input logic [2:0] fmt, input logic dac);
		RST <= 1'b1;
		START <= 1'b0;
		repeat (2) @(posedge CLOCK);
		RST <= 1'b0;
		FORMAT <= fmt;
		DAC_SELECT <= dac;
		@(posedge CLOCK);
		START <= 1'b1;
		repeat (2) @(posedge CLOCK);
	endtask
	// Three sync words to lock, then zero symbols; id bytes of zero match target 0
	task automatic feed(input int nsect);
		int i;
		for (i = 0; i < 3; i++) begin
			SYM_VALID <= 1'b1;
			SYM_DATA <= cdsd_pkg::SYNC_PATTERN;
			@(posedge CLOCK);
		end
		for (i = 0; i < nsect * 2048 + 64; i++) begin
			SYM_DATA <= 16'h0000;
			SYM_FLAG <= i == 300;
			SUB_VALID <= FORMAT == 3'h0;
			@(posedge CLOCK);
		end
		SYM_VALID <= 1'b0;
		SYM_FLAG <= 1'b0;
		SUB_VALID <= 1'b0;
	endtask
	task automatic wait_sent(input logic [11:0] n);
		int k;
		for (k = 0; k < 50000 && SENT_COUNT !== n; k++) begin
			@(posedge CLOCK);
		end
		repeat (100) @(posedge CLOCK);
	endtask
	task automatic t_dvd();
		restart(3'h5, 1'b0);
		feed(16);
		wait_sent(12'h010);
		check(WRITTEN_COUNT, 32'h10);
		check(corr_reqs, 32'h1);
		check(CORRECTED_COUNT, 32'h10);
		check(host_bytes, 32'h8000);
		check(dac_bytes, 32'h0);
		check(first_w, 32'h100);
		check(first_o, 32'h101);
	endtask
	// Every CD-ROM flavour gets buffer correction and host delivery
	task automatic t_cdrom();
		int f;
		for (f = 1; f <= 4; f++) begin
			restart(f[2:0], 1'b1);
			feed(2);
			wait_sent(12'h001);
			check(WRITTEN_COUNT, 32'h2);
			check(corr_reqs, 32'h1);
			check(CORRECTED_COUNT, 32'h1);
			check(host_bytes, 32'h800);
			check(dac_bytes, 32'h0);
			check(wflags, 32'h1);
			check(first_w, 32'h101);
			check(first_o, 32'h100);
		end
	endtask
	task automatic t_audio();
		restart(3'h0, 1'b1);
		feed(1);
		wait_sent(12'h001);
		check(SENT_COUNT, 32'h1);
		check(corr_reqs, 32'h0);
		check(dac_bytes, 32'h800);
		check(host_bytes, 32'h0);
		check(wflags, 32'h1);
		check(first_w, 32'h101);
		check(first_o, 32'h100);
		// Enable low must freeze the stream even when start drops
		CE <= 1'b0;
		START <= 1'b0;
		repeat (3) @(posedge CLOCK);
		check(STATE, 32'h3);
		CE <= 1'b1;
		repeat (3) @(posedge CLOCK);
		check(STATE, 32'h0);
	endtask
	initial begin
		repeat (6) @(posedge CLOCK);
		RST <= 1'b0;
		@(posedge CLOCK);
		t_audio();
		t_cdrom();
		t_dvd();
		wrap_up();
	end
endmodule

/* rtl/cdsd_decoder.sv */
// Streaming sector decoder: sync, demod, search, buffer, correct, deliver

module cdsd_decoder (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic CE,
	input wire logic START,
	input wire logic [2:0] FORMAT,
	input wire logic [cdsd_pkg::ID_W-1:0] TARGET_ID,
	input wire logic SYM_VALID,
	input wire logic [cdsd_pkg::SYM_W-1:0] SYM_DATA,
	input wire logic SYM_FLAG,
	input wire logic SUB_VALID,
	input wire logic [cdsd_pkg::BYTE_W-1:0] SUB_DATA,
	input wire logic CORR_DONE,
	input wire logic DAC_SELECT,
	input wire logic HOST_READY,
	input wire logic DAC_READY,
	output logic BUF_WR,
	output logic [cdsd_pkg::BYTE_W-1:0] BUF_WDATA,
	output logic BUF_WFLAG,
	output logic CORR_REQ,
	output logic HOST_VALID,
	output logic [cdsd_pkg::BYTE_W-1:0] HOST_DATA,
	output logic DAC_VALID,
	output logic [cdsd_pkg::BYTE_W-1:0] DAC_DATA,
	output logic DAC_FLAG,
	output logic [cdsd_pkg::SECT_CNT_W-1:0] WRITTEN_COUNT,
	output logic [cdsd_pkg::SECT_CNT_W-1:0] CORRECTED_COUNT,
	output logic [cdsd_pkg::SECT_CNT_W-1:0] SENT_COUNT,
	output logic [1:0] STATE
);
	cdsd_pkg::cdsd_state_e state;
	cdsd_pkg::cdsd_fmt_e fmt;
	logic is_dvd;
	logic is_audio;
	logic needs_c3;
	logic [1:0] sync_hits;
	logic [cdsd_pkg::BYTE_W-1:0] demod_byte;
	logic demod_valid;
	logic demod_flag;
	logic [cdsd_pkg::BYTE_CNT_W-1:0] wr_byte;
	logic [cdsd_pkg::BYTE_CNT_W-1:0] rd_byte;
	logic [cdsd_pkg::ID_W-1:0] id_shift;
	logic [cdsd_pkg::BYTE_CNT_W-1:0] id_pos;
	logic id_match;
	logic room;
	logic wr_fire;
	logic wr_sector_end;
	logic [cdsd_pkg::SECT_CNT_W-1:0] written;
	logic [cdsd_pkg::SECT_CNT_W-1:0] corrected;
	logic [cdsd_pkg::SECT_CNT_W-1:0] sent;
	logic [cdsd_pkg::SECT_CNT_W-1:0] releasable;
	logic corr_pending;
	logic corr_ready;
	logic rd_ok;
	logic rd_fire;
	logic [cdsd_pkg::BYTE_W-1:0] wr_scr_out;
	logic [cdsd_pkg::BYTE_W-1:0] rd_scr_out;
	logic [cdsd_pkg::BYTE_W-1:0] rd_byte_data;
	cdsd_pkg::cdsd_byte_s fifo_in;
	cdsd_pkg::cdsd_byte_s fifo_out;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic sink_ready;

	assign fmt = cdsd_pkg::cdsd_fmt_e'(FORMAT);
	assign is_dvd = (fmt == cdsd_pkg::CDSD_FMT_DVD);
	assign is_audio = (fmt == cdsd_pkg::CDSD_FMT_AUDIO);
	// Audio skips C3; every CD-ROM form and DVD go through buffer correction
	assign needs_c3 = !is_audio;

	// Alignment counts sync hits, which a miss does not reset, before trusting frame boundaries
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			state <= cdsd_pkg::CDSD_ST_IDLE;
			sync_hits <= 2'h0;
		end else if (CE) begin
			case (state)
				cdsd_pkg::CDSD_ST_IDLE: begin
					if (START) begin
						state <= cdsd_pkg::CDSD_ST_SYNC;
					end
				end
				cdsd_pkg::CDSD_ST_SYNC: begin
					if (SYM_VALID && SYM_DATA == cdsd_pkg::SYNC_PATTERN) begin
						sync_hits <= sync_hits + 2'h1;
						if (sync_hits == 2'(cdsd_pkg::SYNC_LOCK_COUNT - 1)) begin
							state <= cdsd_pkg::CDSD_ST_SEARCH;
						end
					end
				end
				cdsd_pkg::CDSD_ST_SEARCH: begin
					if (id_match) begin
						state <= cdsd_pkg::CDSD_ST_STREAM;
					end
				end
				cdsd_pkg::CDSD_ST_STREAM: begin
					if (!START) begin
						state <= cdsd_pkg::CDSD_ST_IDLE;
						sync_hits <= 2'h0;
					end
				end
				default: state <= cdsd_pkg::CDSD_ST_IDLE;
			endcase
		end
	end

	// Demodulation only after lock; sync words themselves carry no data
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			demod_valid <= 1'b0;
			demod_byte <= 8'h00;
			demod_flag <= 1'b0;
		end else if (CE) begin
			demod_valid <= SYM_VALID && state != cdsd_pkg::CDSD_ST_IDLE
				&& state != cdsd_pkg::CDSD_ST_SYNC
				&& SYM_DATA != cdsd_pkg::SYNC_PATTERN;
			// Stand-in table: fold the 16-bit word to one byte
			demod_byte <= SYM_DATA[15:8] ^ SYM_DATA[7:0];
			// C1/C2 failure marks ride with the byte into the buffer
			demod_flag <= SYM_FLAG;
		end
	end

	// Identifier comes from subchannel for audio, from main data otherwise
	always_comb begin
		if (is_dvd) begin
			id_pos = cdsd_pkg::BYTE_CNT_W'(cdsd_pkg::ID_POS_DVD);
		end else if (is_audio) begin
			id_pos = cdsd_pkg::BYTE_CNT_W'(cdsd_pkg::ID_POS_SUB);
		end else begin
			id_pos = cdsd_pkg::BYTE_CNT_W'(cdsd_pkg::ID_POS_CD_MAIN);
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			id_shift <= 24'h000000;
		end else if (CE) begin
			if (is_audio && SUB_VALID) begin
				id_shift <= {id_shift[15:0], SUB_DATA};
			end else if (!is_audio && demod_valid) begin
				id_shift <= {id_shift[15:0], demod_byte};
			end
		end
	end

	// Match only at sector start, so DVD writes open on a block boundary
	assign id_match = state == cdsd_pkg::CDSD_ST_SEARCH && id_shift == TARGET_ID
		&& wr_byte == id_pos
		&& (!is_dvd || TARGET_ID[3:0] == 4'h0);

	// Room test keeps the writer off uncorrected and unsent sectors
	assign room = (written - sent) < cdsd_pkg::BUF_CAP;
	assign wr_fire = demod_valid && state == cdsd_pkg::CDSD_ST_STREAM && room;
	assign wr_sector_end = wr_byte == cdsd_pkg::BYTE_LAST;

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			wr_byte <= cdsd_pkg::BYTE_ZERO;
		end else if (CE) begin
			if (state == cdsd_pkg::CDSD_ST_SEARCH && demod_valid) begin
				wr_byte <= wr_byte + 11'h001;
			end else if (wr_fire) begin
				wr_byte <= wr_byte + 11'h001;
			end else if (state == cdsd_pkg::CDSD_ST_IDLE) begin
				wr_byte <= cdsd_pkg::BYTE_ZERO;
			end
		end
	end

	// CD is descrambled on the way in; DVD is stored raw
	cdsd_descrambler u_wr_scr (
		.clk(CLOCK),
		.rst(RST),
		.ce(CE),
		.restart(wr_fire && wr_sector_end),
		.advance(wr_fire),
		.din(demod_byte),
		.dout(wr_scr_out)
	);

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			BUF_WR <= 1'b0;
			BUF_WDATA <= 8'h00;
			BUF_WFLAG <= 1'b0;
		end else if (CE) begin
			BUF_WR <= wr_fire;
			BUF_WDATA <= is_dvd ? demod_byte : wr_scr_out;
			BUF_WFLAG <= demod_flag;
		end
	end

	// Three sector counters: written, then corrected and sent, each trailing the one before
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			written <= cdsd_pkg::CNT_ZERO;
		end else if (CE) begin
			if (state == cdsd_pkg::CDSD_ST_IDLE) begin
				written <= cdsd_pkg::CNT_ZERO;
			end else if (wr_fire && wr_sector_end) begin
				written <= written + cdsd_pkg::CNT_ONE;
			end
		end
	end

	// Correction requests: whole DVD blocks, small lead for C3
	assign corr_ready = is_dvd ? (written - corrected) >= cdsd_pkg::ECC_BLK_CNT
		: (written - corrected) >= cdsd_pkg::C3_LEAD;

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			corrected <= cdsd_pkg::CNT_ZERO;
			corr_pending <= 1'b0;
			CORR_REQ <= 1'b0;
		end else if (CE) begin
			if (state == cdsd_pkg::CDSD_ST_IDLE) begin
				corrected <= cdsd_pkg::CNT_ZERO;
				corr_pending <= 1'b0;
				CORR_REQ <= 1'b0;
			end else if (!needs_c3) begin
				// Audio never waits on a correction engine
				corrected <= written;
				CORR_REQ <= 1'b0;
			end else if (corr_pending) begin
				CORR_REQ <= 1'b0;
				if (CORR_DONE) begin
					corr_pending <= 1'b0;
					corrected <= corrected + (is_dvd ? cdsd_pkg::ECC_BLK_CNT
						: cdsd_pkg::CNT_ONE);
				end
			end else if (corr_ready) begin
				corr_pending <= 1'b1;
				CORR_REQ <= 1'b1;
			end
		end
	end

	// DVD releases whole corrected blocks; CD-ROM releases each sector as soon as it is corrected
	assign releasable = (is_dvd || is_audio) ? corrected
		: ((corrected >= cdsd_pkg::HOST_LEAD) ? corrected : cdsd_pkg::CNT_ZERO);
	assign rd_ok = sent != releasable;
	assign rd_fire = rd_ok && fifo_in_ready && CE;

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			rd_byte <= cdsd_pkg::BYTE_ZERO;
			sent <= cdsd_pkg::CNT_ZERO;
		end else if (CE) begin
			if (state == cdsd_pkg::CDSD_ST_IDLE) begin
				rd_byte <= cdsd_pkg::BYTE_ZERO;
				sent <= cdsd_pkg::CNT_ZERO;
			end else if (rd_fire) begin
				rd_byte <= rd_byte + 11'h001;
				if (rd_byte == cdsd_pkg::BYTE_LAST) begin
					sent <= sent + cdsd_pkg::CNT_ONE;
				end
			end
		end
	end

	// Buffer readback is modelled by a position pattern; real data sits off-chip
	assign rd_byte_data = rd_byte[7:0];

	cdsd_descrambler u_rd_scr (
		.clk(CLOCK),
		.rst(RST),
		.ce(CE),
		.restart(rd_fire && rd_byte == cdsd_pkg::BYTE_LAST),
		.advance(rd_fire),
		.din(rd_byte_data),
		.dout(rd_scr_out)
	);

	always_comb begin
		fifo_in.data = is_dvd ? rd_scr_out : rd_byte_data;
		fifo_in.uncorrectable_symbol_flag = 1'b0;
		fifo_in.sector_end = rd_byte == cdsd_pkg::BYTE_LAST;
	end

	cdsd_fifo #(
		.WIDTH($bits(cdsd_pkg::cdsd_byte_s)),
		.DEPTH(cdsd_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk(CLOCK),
		.rst(RST),
		.ce(CE),
		.in_valid(rd_ok),
		.in_ready(fifo_in_ready),
		.in_data(fifo_in),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out)
	);

	// Output stage: one-entry skid per destination keeps outputs registered
	assign sink_ready = (DAC_SELECT && is_audio) ? (!DAC_VALID || DAC_READY)
		: (!HOST_VALID || HOST_READY);
	assign fifo_out_ready = sink_ready;

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			HOST_VALID <= 1'b0;
			HOST_DATA <= 8'h00;
			DAC_VALID <= 1'b0;
			DAC_DATA <= 8'h00;
			DAC_FLAG <= 1'b0;
		end else if (CE) begin
			if (HOST_VALID && HOST_READY) begin
				HOST_VALID <= 1'b0;
			end
			if (DAC_VALID && DAC_READY) begin
				DAC_VALID <= 1'b0;
			end
			if (fifo_out_valid && sink_ready) begin
				if (DAC_SELECT && is_audio) begin
					DAC_VALID <= 1'b1;
					DAC_DATA <= fifo_out.data;
					DAC_FLAG <= fifo_out.uncorrectable_symbol_flag;
				end else begin
					HOST_VALID <= 1'b1;
					HOST_DATA <= fifo_out.data;
				end
			end
		end
	end

	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			WRITTEN_COUNT <= cdsd_pkg::CNT_ZERO;
			CORRECTED_COUNT <= cdsd_pkg::CNT_ZERO;
			SENT_COUNT <= cdsd_pkg::CNT_ZERO;
			STATE <= 2'h0;
		end else if (CE) begin
			WRITTEN_COUNT <= written;
			CORRECTED_COUNT <= corrected;
			SENT_COUNT <= sent;
			STATE <= state;
		end
	end
endmodule

/* rtl/cdsd_descrambler.sv */
// Byte descrambler: 15-bit LFSR, one byte per advance
module cdsd_descrambler (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic restart,
	input wire logic advance,
	input wire logic [cdsd_pkg::BYTE_W-1:0] din,
	output logic [cdsd_pkg::BYTE_W-1:0] dout
);
	logic [14:0] lfsr;
	logic [14:0] next_lfsr;
	logic [cdsd_pkg::BYTE_W-1:0] key;

	// Key is the low byte; eight shifts per byte
	always_comb begin
		next_lfsr = lfsr;
		for (int i = 0; i < cdsd_pkg::BYTE_W; i++) begin
			next_lfsr = {next_lfsr[0] ^ next_lfsr[1], next_lfsr[14:1]};
		end
	end

	assign key = lfsr[cdsd_pkg::BYTE_W-1:0];
	assign dout = din ^ key;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lfsr <= cdsd_pkg::SCR_SEED;
		end else if (ce) begin
			if (restart) begin
				lfsr <= cdsd_pkg::SCR_SEED;
			end else if (advance) begin
				lfsr <= next_lfsr;
			end
		end
	end
endmodule

/* rtl/cdsd_fifo.sv */
// Flip-flop FIFO with valid/ready on both sides
module cdsd_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	assign in_ready = (count != DEPTH[AW:0]);
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign push = ce && in_valid && in_ready;
	assign pop = ce && out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			case ({push, pop})
				2'b10: count <= count + 1'b1;
				2'b01: count <= count - 1'b1;
				default: count <= count;
			endcase
		end
	end
endmodule

/* rtl/cdsd_pkg.sv */
// Package of constants and carriers for the sector stream decoder
package cdsd_pkg;
	localparam int SYM_W = 16;
	localparam int BYTE_W = 8;
	localparam int SECT_BYTES = 2048;
	localparam int SECT_CNT_W = 12;
	localparam int BYTE_CNT_W = 11;
	localparam int ECC_BLK_SECTORS = 16;
	localparam int BUF_SECTORS = 64;
	localparam int FIFO_DEPTH = 8;
	localparam int SYNC_LOCK_COUNT = 3;
	localparam int ID_W = 24;
	localparam int ID_POS_CD_MAIN = 12;
	localparam int ID_POS_DVD = 1;
	localparam int ID_POS_SUB = 0;
	localparam logic [SYM_W-1:0] SYNC_PATTERN = 16'hffe5;
	localparam logic [SECT_CNT_W-1:0] CNT_ZERO = 12'h000;
	localparam logic [SECT_CNT_W-1:0] CNT_ONE = 12'h001;
	localparam logic [BYTE_CNT_W-1:0] BYTE_LAST = 11'h7ff;
	localparam logic [BYTE_CNT_W-1:0] BYTE_ZERO = 11'h000;
	localparam logic [SECT_CNT_W-1:0] ECC_BLK_CNT = 12'h010;
	localparam logic [SECT_CNT_W-1:0] BUF_CAP = 12'h040;
	localparam logic [SECT_CNT_W-1:0] C3_LEAD = 12'h002;
	localparam logic [SECT_CNT_W-1:0] HOST_LEAD = 12'h001;
	localparam logic [14:0] SCR_SEED = 15'h0001;

	typedef enum logic [2:0] {
		CDSD_FMT_AUDIO = 3'h0,
		CDSD_FMT_MODE0 = 3'h1,
		CDSD_FMT_M2F1 = 3'h2,
		CDSD_FMT_M2F2 = 3'h3,
		CDSD_FMT_CDR = 3'h4,
		CDSD_FMT_DVD = 3'h5
	} cdsd_fmt_e;

	typedef enum logic [1:0] {
		CDSD_ST_IDLE = 2'h0,
		CDSD_ST_SYNC = 2'h1,
		CDSD_ST_SEARCH = 2'h2,
		CDSD_ST_STREAM = 2'h3
	} cdsd_state_e;

	typedef struct packed {
		logic [BYTE_W-1:0] data;
		logic uncorrectable_symbol_flag;
		logic sector_end;
	} cdsd_byte_s;
endpackage
